// ### src/cias_top.sv
// Interrupt acceptance, priority resolution and stacking sequencer
// Function
// - Enable flag zero blocks every maskable source
// - Pending bit sets on request, clears on acceptance
// - Level zero disables; seven is highest
// - Accept: enabled, pending, level above threshold
// - Threshold seven blocks all maskable sources
// - Flag, pending, level, threshold stored independently
// - Evaluate at instruction end, sequence next cycle
// - String and accumulate ops suspend midway
// - Read address zero, then clear pending bit
// - Copy flags, clear enable, step, stack select
// - Push flags, push counter, vector, load level
// - Threshold: own level, seven, or unchanged
// - First item: flags high, counter high, flags low
// - Odd stack pointer: byte-wide stacking
// - Interrupt stack unless high software trap
// - Return pops flags and counter, resumes
// - Highest wins; equal levels by fixed order
// - Software traps bypass all priority checks
// - Six pins raise requests on selected edge
// - Pins four, five replace serial channels
// - Flags hold enable and threshold; per-source control
// - Four-byte vector loaded into program counter
`timescale 1ns/1ps
module cias_top (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Request sources
	input wire logic [cias_pkg::NSRC-1:0] periph_req_i,
	input wire logic [cias_pkg::NPIN-1:0] ext_pin_i,
	input wire logic [7:0] polarity_sel_i,
	input wire logic nmi_req_i,
	input wire logic wdt_req_i,
	// Source control writes
	input wire logic ctrl_wr_i,
	input wire logic [3:0] ctrl_idx_i,
	input wire logic [3:0] ctrl_wdata_i,
	// Flag register writes
	input wire logic flg_wr_i,
	input wire logic [15:0] flg_wdata_i,
	// Pipeline
	input wire logic insn_done_i,
	input wire logic long_op_i,
	input wire logic sw_trap_i,
	input wire logic [5:0] sw_trap_num_i,
	input wire logic return_from_interrupt_op_i,
	input wire logic [19:0] pc_i,
	input wire logic [19:0] vtb_i,
	input wire logic [19:0] isp_i,
	input wire logic [19:0] usp_i,
	// Memory
	output logic mem_req_o,
	output logic mem_we_o,
	output logic mem_byte_o,
	output logic [19:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i,
	// Results
	output logic [15:0] flg_o,
	output logic [cias_pkg::NSRC-1:0] pending_o,
	output logic seq_busy_o,
	output logic suspend_o,
	output logic [5:0] int_num_o,
	output logic pc_load_o,
	output logic [19:0] pc_new_o,
	output logic sp_wr_o,
	output logic sp_sel_o,
	output logic [19:0] sp_new_o
);
	cias_pkg::cias_state_e state_q;
	cias_pkg::cias_state_e state_d;
	cias_pkg::cias_kind_e kind_q;
	logic [2:0] lvl_q [cias_pkg::NSRC];
	logic [cias_pkg::NPIN-1:0] pin_evt;
	logic [cias_pkg::NSRC-1:0] src_set;
	logic [cias_pkg::NSRC-1:0] src_clr;
	logic nmi_pend_q;
	logic wdt_pend_q;
	logic [15:0] tmp_flg_q;
	logic [19:0] pc_save_q;
	logic [19:0] sp_base_q;
	logic [19:0] vec_q;
	logic [15:0] word_lo_q;
	logic [7:0] byte_lo_q;
	logic [3:0] src_acc_q;
	logic [2:0] lvl_acc_q;
	logic half_q;
	logic [2:0] best_lvl;
	logic [3:0] best_src;
	logic best_ok;
	logic eval;
	logic take_mask;
	logic take_nmi;
	logic take_wdt;
	logic start;
	logic trap_hi;
	logic [19:0] x_addr;
	logic [15:0] x_data;
	logic x_we;
	logic x_on;
	logic x_odd;
	logic x_last;
	logic [15:0] rd_word;

	// ----------------------------------------------------------------
	// External pins
	// ----------------------------------------------------------------
	for (genvar g = 0; g < cias_pkg::NPIN; g++) begin : g_pin
		cias_edge_det u_edge (
			.mclk_i(mclk_i),
			.rst_n_i(rst_n_i),
			.pin_i(ext_pin_i[g]),
			.rise_sel_i(polarity_sel_i[g]),
			.edge_o(pin_evt[g])
		);
	end

	always_comb begin
		src_set = periph_req_i;
		for (int i = 0; i < cias_pkg::SRC_EXT4; i++) begin
			src_set[i] = pin_evt[i];
		end
		if (polarity_sel_i[cias_pkg::SEL_EXT4_BIT]) begin
			src_set[cias_pkg::SRC_EXT4] = pin_evt[cias_pkg::SRC_EXT4];
		end
		if (polarity_sel_i[cias_pkg::SEL_EXT5_BIT]) begin
			src_set[cias_pkg::SRC_EXT5] = pin_evt[cias_pkg::SRC_EXT5];
		end
	end

	// ----------------------------------------------------------------
	// Per-source control
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < cias_pkg::NSRC; i++) begin
			src_clr[i] = (ctrl_wr_i && ctrl_idx_i == 4'(i)
				&& !ctrl_wdata_i[3])
				|| (state_q == cias_pkg::ST_INFO && x_last
				&& kind_q == cias_pkg::K_MASK && src_acc_q == 4'(i));
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pending_o <= '0;
		end else begin
			pending_o <= (pending_o & ~src_clr) | src_set;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < cias_pkg::NSRC; i++) begin
				lvl_q[i] <= cias_pkg::LVL_RST;
			end
		end else if (ctrl_wr_i && ctrl_idx_i < 4'(cias_pkg::NSRC)) begin
			lvl_q[ctrl_idx_i] <= ctrl_wdata_i[2:0];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			nmi_pend_q <= 1'b0;
			wdt_pend_q <= 1'b0;
		end else begin
			nmi_pend_q <= nmi_req_i
				| (nmi_pend_q & ~(start && take_nmi && !sw_trap_i && !return_from_interrupt_op_i));
			wdt_pend_q <= wdt_req_i
				| (wdt_pend_q & ~(start && take_wdt && !sw_trap_i && !return_from_interrupt_op_i));
		end
	end

	// ----------------------------------------------------------------
	// Priority resolution
	// ----------------------------------------------------------------
	always_comb begin
		best_lvl = flg_o[cias_pkg::IPL_LSB +: 3];
		best_src = '0;
		best_ok = 1'b0;
		for (int k = 0; k < cias_pkg::NSRC; k++) begin
			if (pending_o[cias_pkg::RANK[k]]
				&& lvl_q[cias_pkg::RANK[k]] > best_lvl) begin
				best_lvl = lvl_q[cias_pkg::RANK[k]];
				best_src = cias_pkg::RANK[k];
				best_ok = 1'b1;
			end
		end
	end

	assign eval = insn_done_i | long_op_i;
	assign take_mask = eval && best_ok && flg_o[cias_pkg::FLG_I_BIT];
	assign take_nmi = eval && nmi_pend_q
		&& (cias_pkg::NMI_BEFORE_WDT || !wdt_pend_q);
	assign take_wdt = eval && wdt_pend_q && !take_nmi;
	assign start = state_q == cias_pkg::ST_IDLE && (return_from_interrupt_op_i || sw_trap_i
		|| take_nmi || take_wdt || take_mask);
	assign trap_hi = sw_trap_num_i >= cias_pkg::TRAP_USP_MIN;

	// ----------------------------------------------------------------
	// Acceptance capture
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			kind_q <= cias_pkg::K_MASK;
			src_acc_q <= '0;
			lvl_acc_q <= '0;
			int_num_o <= '0;
			pc_save_q <= '0;
			sp_base_q <= '0;
			sp_sel_o <= 1'b0;
			vec_q <= '0;
			suspend_o <= 1'b0;
		end else begin
			suspend_o <= 1'b0;
			if (start) begin
				pc_save_q <= pc_i;
				suspend_o <= !return_from_interrupt_op_i && !sw_trap_i && !insn_done_i;
				sp_sel_o <= flg_o[cias_pkg::FLG_U_BIT];
				sp_base_q <= flg_o[cias_pkg::FLG_U_BIT] ? usp_i : isp_i;
				if (!return_from_interrupt_op_i && !(sw_trap_i && trap_hi)) begin
					sp_sel_o <= 1'b0;
					sp_base_q <= isp_i;
				end
				if (sw_trap_i) begin
					kind_q <= cias_pkg::K_TRAP;
					int_num_o <= sw_trap_num_i;
					vec_q <= vtb_i + (20'(sw_trap_num_i) << cias_pkg::VEC_SHIFT);
				end else if (take_nmi) begin
					kind_q <= cias_pkg::K_NMI;
					vec_q <= cias_pkg::NMI_VEC;
				end else if (take_wdt) begin
					kind_q <= cias_pkg::K_WDT;
					vec_q <= cias_pkg::WDT_VEC;
				end else begin
					kind_q <= cias_pkg::K_MASK;
					src_acc_q <= best_src;
					lvl_acc_q <= best_lvl;
					int_num_o <= cias_pkg::SRC_NUM_BASE + 6'(best_src);
					vec_q <= vtb_i + (20'(cias_pkg::SRC_NUM_BASE + 6'(best_src))
						<< cias_pkg::VEC_SHIFT);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Memory transfers
	// ----------------------------------------------------------------
	always_comb begin
		x_on = 1'b1;
		x_we = 1'b0;
		x_data = '0;
		x_addr = '0;
		unique case (state_q)
			cias_pkg::ST_INFO: x_addr = cias_pkg::INFO_ADDR;
			cias_pkg::ST_PUSH_F: begin
				x_addr = sp_base_q - cias_pkg::ITEM_STEP;
				x_we = 1'b1;
				x_data = {tmp_flg_q[15:12], pc_save_q[19:16],
					tmp_flg_q[7:0]};
			end
			cias_pkg::ST_PUSH_PC: begin
				x_addr = sp_base_q - cias_pkg::FRAME_SIZE;
				x_we = 1'b1;
				x_data = pc_save_q[15:0];
			end
			cias_pkg::ST_VEC_LO: x_addr = vec_q;
			cias_pkg::ST_VEC_HI: x_addr = vec_q + cias_pkg::ITEM_STEP;
			cias_pkg::ST_POP_PC: x_addr = sp_base_q;
			cias_pkg::ST_POP_F: x_addr = sp_base_q + cias_pkg::ITEM_STEP;
			cias_pkg::ST_IDLE, cias_pkg::ST_FIN,
			cias_pkg::ST_RFIN: x_on = 1'b0;
		endcase
	end

	assign x_odd = x_addr[0];
	assign x_last = mem_req_o && mem_ack_i && (!x_odd || half_q);
	assign rd_word = x_odd ? {mem_rdata_i[7:0], byte_lo_q} : mem_rdata_i;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_byte_o <= 1'b0;
			mem_addr_o <= '0;
			mem_wdata_o <= '0;
			half_q <= 1'b0;
			byte_lo_q <= '0;
		end else begin
			mem_req_o <= x_on && !(mem_req_o && mem_ack_i);
			mem_we_o <= x_we;
			mem_byte_o <= x_odd;
			mem_addr_o <= x_addr + 20'(half_q);
			mem_wdata_o <= half_q ? {8'h00, x_data[15:8]} : x_data;
			if (mem_req_o && mem_ack_i) begin
				half_q <= x_odd && !half_q;
				byte_lo_q <= mem_rdata_i[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			cias_pkg::ST_IDLE: begin
				if (start) begin
					state_d = return_from_interrupt_op_i ? cias_pkg::ST_POP_PC
						: cias_pkg::ST_INFO;
				end
			end
			cias_pkg::ST_INFO: if (x_last) state_d = cias_pkg::ST_PUSH_F;
			cias_pkg::ST_PUSH_F: if (x_last) state_d = cias_pkg::ST_PUSH_PC;
			cias_pkg::ST_PUSH_PC: if (x_last) state_d = cias_pkg::ST_VEC_LO;
			cias_pkg::ST_VEC_LO: if (x_last) state_d = cias_pkg::ST_VEC_HI;
			cias_pkg::ST_VEC_HI: if (x_last) state_d = cias_pkg::ST_FIN;
			cias_pkg::ST_POP_PC: if (x_last) state_d = cias_pkg::ST_POP_F;
			cias_pkg::ST_POP_F: if (x_last) state_d = cias_pkg::ST_RFIN;
			cias_pkg::ST_FIN, cias_pkg::ST_RFIN: state_d = cias_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_q <= cias_pkg::ST_IDLE;
			seq_busy_o <= 1'b0;
		end else begin
			state_q <= state_d;
			seq_busy_o <= state_d != cias_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			word_lo_q <= '0;
		end else if (x_last && (state_q == cias_pkg::ST_VEC_LO
			|| state_q == cias_pkg::ST_POP_PC)) begin
			word_lo_q <= rd_word;
		end
	end

	// ----------------------------------------------------------------
	// Flag register, program counter and stack pointer results
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			flg_o <= cias_pkg::FLG_RST;
			tmp_flg_q <= cias_pkg::FLG_RST;
		end else if (start && !return_from_interrupt_op_i) begin
			tmp_flg_q <= flg_o;
			flg_o[cias_pkg::FLG_I_BIT] <= 1'b0;
			flg_o[cias_pkg::FLG_D_BIT] <= 1'b0;
			if (!(sw_trap_i && trap_hi)) begin
				flg_o[cias_pkg::FLG_U_BIT] <= 1'b0;
			end
		end else if (state_q == cias_pkg::ST_FIN) begin
			if (kind_q == cias_pkg::K_MASK) begin
				flg_o[cias_pkg::IPL_LSB +: 3] <= lvl_acc_q;
			end else if (kind_q != cias_pkg::K_TRAP) begin
				flg_o[cias_pkg::IPL_LSB +: 3] <= cias_pkg::IPL_MAX;
			end
		end else if (state_q == cias_pkg::ST_POP_F && x_last) begin
			flg_o <= {rd_word[15:12], 4'h0, rd_word[7:0]};
		end else if (flg_wr_i) begin
			flg_o <= flg_wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pc_load_o <= 1'b0;
			pc_new_o <= '0;
			sp_wr_o <= 1'b0;
			sp_new_o <= '0;
		end else begin
			pc_load_o <= 1'b0;
			sp_wr_o <= 1'b0;
			if (state_q == cias_pkg::ST_VEC_HI && x_last) begin
				pc_load_o <= 1'b1;
				pc_new_o <= {rd_word[3:0], word_lo_q};
				sp_wr_o <= 1'b1;
				sp_new_o <= sp_base_q - cias_pkg::FRAME_SIZE;
			end else if (state_q == cias_pkg::ST_POP_F && x_last) begin
				pc_load_o <= 1'b1;
				pc_new_o <= {rd_word[11:8], word_lo_q};
				sp_wr_o <= 1'b1;
				sp_new_o <= sp_base_q + cias_pkg::FRAME_SIZE;
			end
		end
	end
endmodule

// ### src/cias_pkg.sv
// Constants and types of the interrupt acceptance sequencer
package cias_pkg;

	// ----------------------------------------------------------------
	// Sources
	// ----------------------------------------------------------------
	localparam int NSRC = 12;
	localparam int NPIN = 6;
	localparam int SRC_EXT4 = 4;
	localparam int SRC_EXT5 = 5;
	localparam int SEL_EXT4_BIT = 6;
	localparam int SEL_EXT5_BIT = 7;
	localparam logic [5:0] SRC_NUM_BASE = 6'h04;
	localparam logic [5:0] TRAP_USP_MIN = 6'h20;
	// Tie-break ranking, first entry wins among equal levels
	localparam logic [3:0] RANK [NSRC] = '{4'h0, 4'h1, 4'h2, 4'h3,
		4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
	// Set when the non-maskable request outranks the watchdog
	localparam logic NMI_BEFORE_WDT = 1'h1;

	// ----------------------------------------------------------------
	// Flag register layout and reset
	// ----------------------------------------------------------------
	localparam int FLG_D_BIT = 2;
	localparam int FLG_I_BIT = 6;
	localparam int FLG_U_BIT = 7;
	localparam int IPL_LSB = 12;
	localparam logic [15:0] FLG_RST = 16'h0000;
	localparam logic [2:0] IPL_MAX = 3'h7;
	localparam logic [2:0] LVL_RST = 3'h0;

	// ----------------------------------------------------------------
	// Addresses
	// ----------------------------------------------------------------
	localparam logic [19:0] INFO_ADDR = 20'h00000;
	localparam logic [19:0] WDT_VEC = 20'hffff0;
	localparam logic [19:0] NMI_VEC = 20'hffff8;
	localparam int VEC_SHIFT = 2;
	localparam logic [19:0] ITEM_STEP = 20'h00002;
	localparam logic [19:0] FRAME_SIZE = 20'h00004;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum {
		ST_IDLE, ST_INFO, ST_PUSH_F, ST_PUSH_PC, ST_VEC_LO, ST_VEC_HI,
		ST_FIN, ST_POP_PC, ST_POP_F, ST_RFIN
	} cias_state_e;

	typedef enum {
		K_MASK, K_NMI, K_WDT, K_TRAP
	} cias_kind_e;

endpackage

// ### src/cias_edge_det.sv
// Pin synchroniser and polarity-selected edge detector
`timescale 1ns/1ps
module cias_edge_det (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Pin and polarity (1 rising, 0 falling)
	input wire logic pin_i,
	input wire logic rise_sel_i,
	// One-cycle pulse per qualifying edge
	output logic edge_o
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// Chain follows the pin through reset, so no false edge after it
	always_ff @(posedge mclk_i) begin
		meta_q <= pin_i;
		sync_q <= meta_q;
		prev_q <= sync_q;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			edge_o <= 1'b0;
		end else begin
			edge_o <= rise_sel_i ? (sync_q & ~prev_q)
				: (~sync_q & prev_q);
		end
	end
endmodule

// ### tb/cias_sva.sv
// Port assertions of the interrupt acceptance sequencer
`timescale 1ns/1ps
module cias_sva (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Inputs
	input wire logic insn_done_i,
	input wire logic long_op_i,
	input wire logic sw_trap_i,
	input wire logic return_from_interrupt_op_i,
	input wire logic nmi_req_i,
	input wire logic wdt_req_i,
	input wire logic mem_ack_i,
	// Outputs
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic mem_byte_o,
	input wire logic [19:0] mem_addr_o,
	input wire logic [15:0] flg_o,
	input wire logic seq_busy_o,
	input wire logic suspend_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	property p_mask_off;
		!seq_busy_o && !flg_o[6] && !sw_trap_i && !return_from_interrupt_op_i && !nmi_req_i
			&& !wdt_req_i |=> !seq_busy_o;
	endproperty
	a_mask_off: assert property (p_mask_off)
		else $error("started while masked");
	property p_in_seq;
		mem_req_o |-> seq_busy_o;
	endproperty
	a_in_seq: assert property (p_in_seq)
		else $error("transfer outside sequence");
	property p_hold;
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
			&& $stable(mem_we_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("request dropped early");
	property p_gap;
		mem_req_o && mem_ack_i |=> !mem_req_o;
	endproperty
	a_gap: assert property (p_gap)
		else $error("no gap after answer");
	property p_info;
		$rose(seq_busy_o) && !$past(return_from_interrupt_op_i) |-> ##[0:1] (mem_req_o
			&& !mem_we_o && mem_addr_o == cias_pkg::INFO_ADDR);
	endproperty
	a_info: assert property (p_info)
		else $error("first read not at zero");
	property p_clr;
		$rose(seq_busy_o) && !$past(return_from_interrupt_op_i) |-> !flg_o[6] && !flg_o[2];
	endproperty
	a_clr: assert property (p_clr)
		else $error("flags not cleared");
	property p_odd;
		mem_req_o && mem_we_o && mem_addr_o[0] |-> mem_byte_o;
	endproperty
	a_odd: assert property (p_odd)
		else $error("odd address written wide");
	property p_susp;
		$rose(seq_busy_o) && $past(long_op_i) && !$past(insn_done_i)
			&& !$past(return_from_interrupt_op_i) && !$past(sw_trap_i) |-> suspend_o;
	endproperty
	a_susp: assert property (p_susp)
		else $error("long op not suspended");
	property p_ends;
		$rose(seq_busy_o) |-> ##[1:200] !seq_busy_o;
	endproperty
	a_ends: assert property (p_ends)
		else $error("sequence hangs");
endmodule
bind cias_top cias_sva cias_sva_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.insn_done_i(insn_done_i), .long_op_i(long_op_i),
	.sw_trap_i(sw_trap_i), .return_from_interrupt_op_i(return_from_interrupt_op_i), .nmi_req_i(nmi_req_i),
	.wdt_req_i(wdt_req_i), .mem_ack_i(mem_ack_i), .mem_req_o(mem_req_o),
	.mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o), .mem_addr_o(mem_addr_o),
	.flg_o(flg_o), .seq_busy_o(seq_busy_o), .suspend_o(suspend_o));

// ### tb/cias_mem_model.sv
// Stack and vector memory answering the sequencer
`timescale 1ns/1ps
module cias_mem_model (
	// Clock
	input wire logic mclk_i,
	// Request
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic mem_byte_i,
	input wire logic [19:0] mem_addr_i,
	input wire logic [15:0] mem_wdata_i,
	input wire logic [1:0] delay_i,
	// Answer
	output logic mem_ack_o,
	output logic [15:0] mem_rdata_o
);
	logic [7:0] mem [int];
	int cnt = 0;
	function automatic logic [7:0] rd(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5a);
	endfunction
	initial begin
		mem_ack_o = 1'b0;
		mem_rdata_o = 16'h0000;
	end
	// Data lines change every cycle outside an answer
	always @(posedge mclk_i) begin
		if (mem_req_i && !mem_ack_o && cnt >= delay_i) begin
			cnt <= 0;
			mem_ack_o <= 1'b1;
			if (mem_we_i) begin
				mem[mem_addr_i] = mem_wdata_i[7:0];
				if (!mem_byte_i) begin
					mem[mem_addr_i + 20'h1] = mem_wdata_i[15:8];
				end
				mem_rdata_o <= ~mem_rdata_o;
			end else begin
				mem_rdata_o <= {rd(mem_addr_i + 20'h1), rd(mem_addr_i)};
			end
		end else begin
			if (mem_req_i && !mem_ack_o) begin
				cnt <= cnt + 1;
			end
			mem_ack_o <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o;
		end
	end
endmodule

// ### tb/testbench.sv
// Self-checking bench of the interrupt acceptance sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("wrong value %0t %h %h", $time, a, b); end end
module testbench;
	logic mclk_i = 0, rst_n_i = 0, nmi_req_i = 0, wdt_req_i = 0;
	logic ctrl_wr_i = 0, flg_wr_i = 0, insn_done_i = 0, long_op_i = 0;
	logic sw_trap_i = 0, return_from_interrupt_op_i = 0, mem_req_o, mem_we_o, mem_byte_o;
	logic mem_ack_i, seq_busy_o, suspend_o, pc_load_o, sp_wr_o, sp_sel_o;
	logic [11:0] periph_req_i = '0, pending_o, pend;
	logic [5:0] ext_pin_i = '0, sw_trap_num_i = '0, int_num_o;
	logic [7:0] polarity_sel_i = '0;
	logic [3:0] ctrl_idx_i = '0, ctrl_wdata_i = '0;
	logic [15:0] flg_wdata_i = '0, mem_wdata_o, mem_rdata_i, flg_o, fb, fa;
	logic [19:0] pc_i = '0, vtb_i = 20'h10000, isp_i = '0, usp_i = '0;
	logic [19:0] mem_addr_o, pc_new_o, sp_new_o, sp;
	logic [2:0] lvl [12];
	logic [2:0] bl;
	logic [1:0] delay = '0;
	logic [31:0] r;
	logic pol;
	int num_errors = 0, compares = 0, best;
	always #12.5 mclk_i = ~mclk_i;
	cias_top cias_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.periph_req_i(periph_req_i), .ext_pin_i(ext_pin_i),
		.polarity_sel_i(polarity_sel_i), .nmi_req_i(nmi_req_i),
		.wdt_req_i(wdt_req_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_idx_i(ctrl_idx_i),
		.ctrl_wdata_i(ctrl_wdata_i), .flg_wr_i(flg_wr_i),
		.flg_wdata_i(flg_wdata_i), .insn_done_i(insn_done_i),
		.long_op_i(long_op_i), .sw_trap_i(sw_trap_i),
		.sw_trap_num_i(sw_trap_num_i), .return_from_interrupt_op_i(return_from_interrupt_op_i), .pc_i(pc_i),
		.vtb_i(vtb_i), .isp_i(isp_i), .usp_i(usp_i), .mem_req_o(mem_req_o),
		.mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .flg_o(flg_o),
		.pending_o(pending_o), .seq_busy_o(seq_busy_o),
		.suspend_o(suspend_o), .int_num_o(int_num_o), .pc_load_o(pc_load_o),
		.pc_new_o(pc_new_o), .sp_wr_o(sp_wr_o), .sp_sel_o(sp_sel_o),
		.sp_new_o(sp_new_o));
	cias_mem_model cias_mem_model_i (.mclk_i(mclk_i), .mem_req_i(mem_req_o),
		.mem_we_i(mem_we_o), .mem_byte_i(mem_byte_o), .mem_addr_i(mem_addr_o),
		.mem_wdata_i(mem_wdata_o), .delay_i(delay), .mem_ack_o(mem_ack_i),
		.mem_rdata_o(mem_rdata_i));
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic end_sim;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic logic [15:0] w16(input logic [19:0] a);
		return {(a[7:0] + 8'h1) ^ 8'h5a, a[7:0] ^ 8'h5a};
	endfunction
	task automatic wr_ctrl(input int i, input logic [3:0] w);
		tick(1);
		ctrl_wr_i = 1;
		ctrl_idx_i = i[3:0];
		ctrl_wdata_i = w;
		tick(1);
		ctrl_wr_i = 0;
	endtask
	task automatic wr_flg(input logic [15:0] w);
		tick(1);
		flg_wr_i = 1;
		flg_wdata_i = w;
		fb = w;
		tick(1);
		flg_wr_i = 0;
		`CHK(flg_o, w)
	endtask
	task automatic await(input bit load);
		int n;
		n = 0;
		while ((load ? pc_load_o !== 1 : seq_busy_o !== 0) && n < 300) begin
			tick(1);
			n++;
		end
		if (n >= 300) begin
			num_errors++;
		end
	endtask
	// Follow one acceptance and its return through the stack
	task automatic serve(input int num, input logic [19:0] vec,
		input bit usel);
		logic [15:0] hi;
		hi = w16(vec + 20'h2);
		await(1);
		`CHK(pc_new_o, {hi[3:0], w16(vec)})
		`CHK(sp_new_o, sp - 20'h4)
		`CHK({sp_wr_o, sp_sel_o}, {1'b1, usel})
		if (num >= 0) `CHK(int_num_o, num[5:0])
		await(0);
		`CHK(flg_o, fa)
		isp_i = sp - 20'h4;
		usp_i = isp_i;
		return_from_interrupt_op_i = 1;
		tick(1);
		return_from_interrupt_op_i = 0;
		await(1);
		`CHK(pc_new_o, pc_i)
		`CHK(sp_new_o, sp)
		`CHK({sp_wr_o, sp_sel_o}, {1'b1, usel})
		await(0);
		`CHK(flg_o, fb & 16'hf0ff)
	endtask
	initial begin
		void'($urandom(12));
		tick(10);
		rst_n_i = 1;
		`CHK(flg_o, 16'h0000)
		`CHK(pending_o, 12'h000)
		for (int it = 0; it < 24; it++) begin
			r = $urandom;
			delay = r[9:8];
			for (int i = 4; i < 12; i++) begin
				lvl[i] = 3'($urandom_range(7));
				wr_ctrl(i, {1'b0, lvl[i]});
			end
			pend = {r[31:24], 4'h0};
			periph_req_i = pend;
			tick(1);
			periph_req_i = '0;
			wr_flg(r[23:8] | {9'h0, r[0] | r[1], 6'h0});
			`CHK(pending_o, pend)
			best = -1;
			bl = fb[14:12];
			for (int i = 4; i < 12; i++) begin
				if (fb[6] && pend[i] && lvl[i] > bl) begin
					best = i;
					bl = lvl[i];
				end
			end
			sp = {19'h10000, r[2]};
			isp_i = sp;
			pc_i = r[31:12];
			long_op_i = r[3];
			insn_done_i = !r[3];
			tick(1);
			long_op_i = 0;
			insn_done_i = 0;
			if (best < 0) begin
				tick(3);
				`CHK(seq_busy_o, 1'b0)
			end else begin
				fa = (fb & 16'h8f3b) | {1'b0, bl, 12'h0};
				serve(best + 4, vtb_i + 20'((best + 4) * 4), 1'b0);
				`CHK(pending_o, pend & ~(12'h1 << best))
			end
		end
		for (int k = 0; k < 2; k++) begin
			wr_flg(16'h7085);
			sp = k ? 20'h20001 : 20'h30000;
			isp_i = 20'h20001;
			usp_i = 20'h30000;
			sw_trap_num_i = k ? 6'h0a : 6'h28;
			sw_trap_i = 1;
			tick(1);
			sw_trap_i = 0;
			fa = k ? 16'h7001 : 16'h7081;
			serve(sw_trap_num_i, vtb_i + {sw_trap_num_i, 2'h0},
				k == 0);
		end
		for (int k = 0; k < 2; k++) begin
			wr_flg(16'h7040);
			sp = 20'h20000;
			isp_i = sp;
			nmi_req_i = !k;
			wdt_req_i = k;
			insn_done_i = 1;
			tick(1);
			nmi_req_i = 0;
			wdt_req_i = 0;
			tick(1);
			insn_done_i = 0;
			fa = 16'h7000;
			serve(-1, k ? cias_pkg::WDT_VEC : cias_pkg::NMI_VEC,
				1'b0);
		end
		polarity_sel_i = 8'hc0;
		for (int p = 0; p < 6; p++) begin
			pol = 1'($urandom_range(1));
			polarity_sel_i[p] = pol;
			ext_pin_i[p] = ~pol;
			tick(6);
			wr_ctrl(p, 4'h0);
			ext_pin_i[p] = pol;
			tick(5);
			`CHK(pending_o[p], 1'b1)
			wr_ctrl(12 + (p & 3), 4'h0);
			wr_ctrl(p, 4'h8);
			`CHK(pending_o[p], 1'b1)
			wr_ctrl(p, 4'h0);
			ext_pin_i[p] = ~pol;
			periph_req_i = 12'h03f;
			tick(1);
			periph_req_i = '0;
			tick(5);
			`CHK(pending_o[p], 1'b0)
		end
		end_sim;
	end
	initial begin
		tick(20000);
		num_errors++;
		end_sim;
	end
endmodule
